// File: rtl/bmc_regs.svh
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH

// Register index on the management bus
`define BMC_ADDR 5'h00
// Field positions
`define BMC_PWR_DOWN_BIT 11
`define BMC_ISOLATE_BIT 10
`define BMC_RESTART_BIT 9
`define BMC_DUPLEX_BIT 8
`define BMC_COL_TEST_BIT 7
// Reset values
`define BMC_PWR_DOWN_RST 1'h0
`define BMC_ISOLATE_RST 1'h0
`define BMC_RESTART_RST 1'h0
`define BMC_DUPLEX_RST 1'h0
`define BMC_COL_TEST_RST 1'h0
// Management frame figures
`define MDIO_PREAMBLE_BITS 6'h20
`define MDIO_HDR_BITS 5'h0c
`define MDIO_DATA_BITS 5'h10
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`endif

// File: rtl/bmc_pkg.sv
package bmc_pkg;
    typedef enum logic [2:0] {
        MG_IDLE,
        MG_START,
        MG_HDR,
        MG_TA,
        MG_DATA
    } mgmt_state_e;
endpackage

// File: rtl/basic_mode_control_upper.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmc_regs.svh"

module basic_mode_control_upper #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_reset,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic power_down_interrupt_pin_n,
    input wire logic duplex_strap,
    input wire logic an_enable,
    input wire logic an_started,
    input wire logic an_duplex_full,
    input wire logic tx_en,
    output logic col,
    output logic col_oe,
    output logic mii_out_oe,
    output logic phy_enable,
    output logic an_restart_req,
    output logic duplex_full
);

    // Two-flop synchronisers for everything arriving from pins
    logic [4:0] sync1_q;
    logic [4:0] sync1_d;
    logic [4:0] sync2_q;
    logic [4:0] sync2_d;
    logic [4:0] sync_in;
    logic mdc_prev_q;
    logic mdc_prev_d;
    logic mdc_rise;
    logic mdio_s;
    logic pd_pin_n_s;
    logic strap_s;
    logic tx_en_s;

    // Pin order inside the synchroniser word, management clock on top
    assign sync_in = {mdc, mdio_in, power_down_interrupt_pin_n, duplex_strap, tx_en};

    // Plain shift chain; the edge detector looks behind the second stage only
    always_comb begin
        sync1_d = sync_in;
        sync2_d = sync1_q;
        mdc_prev_d = sync2_q[4];
    end

    // No reset here on purpose: the chain keeps tracking the pins through
    // reset, so strap and power down pin are settled when reset lets go,
    // and no false clock edge can follow reset whatever level the pin idles at
    always_ff @(posedge clk) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
        mdc_prev_q <= mdc_prev_d;
    end

    // Taps of the second stage
    assign mdio_s = sync2_q[3];
    assign pd_pin_n_s = sync2_q[2];
    assign strap_s = sync2_q[1];
    assign tx_en_s = sync2_q[0];
    assign mdc_rise = sync2_q[4] & ~mdc_prev_q;

    // Management frame engine
    bmc_pkg::mgmt_state_e st_q, st_d;
    logic [5:0] ones_q, ones_d;
    logic [4:0] cnt_q, cnt_d;
    logic [11:0] hdr_q, hdr_d;
    logic [15:0] shift_q, shift_d;
    logic out_q, out_d;
    logic oe_q, oe_d;
    logic wr_pulse;
    logic [15:0] rd_word;
    logic hit;
    logic is_read;
    logic is_write;
    logic phy_match;
    logic [1:0] hdr_op;
    logic [4:0] hdr_phy;
    logic [4:0] hdr_reg;

    // Header fields as they sit after twelve shifts, opcode first
    assign hdr_op = hdr_q[11:10];
    assign hdr_phy = hdr_q[9:5];
    assign hdr_reg = hdr_q[4:0];

    // Only our address answers; another register at our address reads zero
    assign phy_match = (hdr_phy == PHY_ADDR);
    assign hit = phy_match && (hdr_reg == `BMC_ADDR);
    assign is_read = (hdr_op == `MDIO_OP_READ);
    assign is_write = (hdr_op == `MDIO_OP_WRITE);

    // Frame walk per management clock rise: preamble ones, start bits,
    // twelve header bits, turnaround, then seventeen data-phase rises.
    // A full preamble is demanded on every frame; no suppression offered.
    always_comb begin
        st_d = st_q;
        ones_d = ones_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        shift_d = shift_q;
        out_d = out_q;
        oe_d = oe_q;
        wr_pulse = 1'h0;
        if (mdc_rise) begin
            unique case (st_q)
                bmc_pkg::MG_IDLE: begin
                    oe_d = 1'h0;
                    // Count preamble ones, saturating at the required length
                    if (mdio_s) begin
                        if (ones_q != `MDIO_PREAMBLE_BITS) begin
                            ones_d = ones_q + 6'h01;
                        end
                    end else begin
                        // A zero after a full preamble is the first start bit
                        if (ones_q == `MDIO_PREAMBLE_BITS) begin
                            st_d = bmc_pkg::MG_START;
                        end
                        ones_d = 6'h00;
                    end
                end
                bmc_pkg::MG_START: begin
                    // Second start bit must be one, otherwise drop the frame
                    cnt_d = 5'h00;
                    st_d = mdio_s ? bmc_pkg::MG_HDR : bmc_pkg::MG_IDLE;
                end
                bmc_pkg::MG_HDR: begin
                    // Opcode, station address, register address, MSB first
                    hdr_d = {hdr_q[10:0], mdio_s};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == `MDIO_HDR_BITS - 5'h01) begin
                        st_d = bmc_pkg::MG_TA;
                        cnt_d = 5'h00;
                    end
                end
                bmc_pkg::MG_TA: begin
                    // First turnaround bit sampled; a read drives zero next
                    st_d = bmc_pkg::MG_DATA;
                    cnt_d = 5'h00;
                    shift_d = rd_word;
                    if (is_read && phy_match) begin
                        oe_d = 1'h1;
                        out_d = 1'h0;
                    end
                end
                bmc_pkg::MG_DATA: begin
                    // Counts 17 edges: second turnaround, then 16 data bits
                    cnt_d = cnt_q + 5'h01;
                    if (oe_q) begin
                        out_d = shift_q[15];
                        shift_d = {shift_q[14:0], 1'h0};
                    end else if (cnt_q != 5'h00) begin
                        shift_d = {shift_q[14:0], mdio_s};
                    end
                    if (cnt_q == `MDIO_DATA_BITS) begin
                        st_d = bmc_pkg::MG_IDLE;
                        oe_d = 1'h0;
                        ones_d = 6'h00;
                        wr_pulse = is_write && hit;
                    end
                end
                default: st_d = bmc_pkg::MG_IDLE;
            endcase
        end
    end

    // Engine registers; running on clk keeps management alive in power down
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= bmc_pkg::MG_IDLE;
            ones_q <= 6'h00;
            cnt_q <= 5'h00;
            hdr_q <= 12'h000;
            shift_q <= 16'h0000;
            out_q <= 1'h0;
            oe_q <= 1'h0;
        end else begin
            st_q <= st_d;
            ones_q <= ones_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            shift_q <= shift_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign mdio_out = out_q;
    assign mdio_oe = oe_q;

    // Control bits
    logic pd_q, pd_d;
    logic iso_q, iso_d;
    logic rs_q, rs_d;
    logic dup_q, dup_d;
    logic ct_q, ct_d;
    logic strap_done_q, strap_done_d;
    logic [15:0] wdata;

    // Last shift step lands in the same cycle as the write pulse
    assign wdata = {shift_q[14:0], mdio_s};

    // Control next values; later ifs override earlier ones, so set beats clear
    always_comb begin
        pd_d = pd_q;
        iso_d = iso_q;
        rs_d = rs_q;
        dup_d = dup_q;
        ct_d = ct_q;
        strap_done_d = 1'h1;
        if (!strap_done_q) begin
            // Strap caught after reset release; synchroniser has settled by then
            dup_d = strap_s;
        end
        if (wr_pulse) begin
            pd_d = wdata[`BMC_PWR_DOWN_BIT];
            iso_d = wdata[`BMC_ISOLATE_BIT];
            dup_d = wdata[`BMC_DUPLEX_BIT];
            ct_d = wdata[`BMC_COL_TEST_BIT];
            // Bits 6:0 are simply never stored
        end
        // Negotiation start clears the bit; a zero write does not
        if (an_started) begin
            rs_d = 1'h0;
        end
        if (wr_pulse && wdata[`BMC_RESTART_BIT] && an_enable) begin
            rs_d = 1'h1;
        end
        // Pin wins over any software write in the same cycle
        if (!pd_pin_n_s) begin
            pd_d = 1'h1;
        end
    end

    // Control flops; software reset clears them and re-takes the strap
    always_ff @(posedge clk) begin
        if (rst || sw_reset) begin
            pd_q <= `BMC_PWR_DOWN_RST;
            iso_q <= `BMC_ISOLATE_RST;
            rs_q <= `BMC_RESTART_RST;
            dup_q <= `BMC_DUPLEX_RST;
            ct_q <= `BMC_COL_TEST_RST;
            strap_done_q <= 1'h0;
        end else begin
            pd_q <= pd_d;
            iso_q <= iso_d;
            rs_q <= rs_d;
            dup_q <= dup_d;
            ct_q <= ct_d;
            strap_done_q <= strap_done_d;
        end
    end

    // Read image; reserved low bits stay zero
    always_comb begin
        rd_word = 16'h0000;
        rd_word[`BMC_PWR_DOWN_BIT] = pd_q;
        rd_word[`BMC_ISOLATE_BIT] = iso_q;
        rd_word[`BMC_RESTART_BIT] = rs_q;
        rd_word[`BMC_DUPLEX_BIT] = dup_q;
        rd_word[`BMC_COL_TEST_BIT] = ct_q;
        // Another register at our address reads as all zeros
        if (!hit) begin
            rd_word = 16'h0000;
        end
    end

    // Datapath side effects
    logic pd_eff;
    logic col_d;
    logic col_q;

    assign pd_eff = pd_q | ~pd_pin_n_s;

    // Transmit enable is ignored while isolated or powered down, so a MAC
    // left running on an isolated port can never fake a collision
    always_comb begin
        col_d = ct_q & tx_en_s & ~iso_q & ~pd_eff;
    end

    // Collision output flop
    always_ff @(posedge clk) begin
        if (rst) begin
            col_q <= 1'h0;
        end else begin
            col_q <= col_d;
        end
    end

    // Sync plus output flop gives about 3 clocks, ample at 10 Mb/s
    assign col = col_q;
    assign col_oe = ~iso_q;
    assign mii_out_oe = ~iso_q;
    assign phy_enable = ~pd_eff;
    assign an_restart_req = rs_q;
    assign duplex_full = an_enable ? an_duplex_full : dup_q;

endmodule // basic_mode_control_upper

`default_nettype wire

// File: verif/bmc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_reset,
    input wire logic power_down_interrupt_pin_n,
    input wire logic an_enable,
    input wire logic an_started,
    input wire logic an_duplex_full,
    input wire logic tx_en,
    input wire logic col,
    input wire logic col_oe,
    input wire logic mii_out_oe,
    input wire logic phy_enable,
    input wire logic an_restart_req,
    input wire logic duplex_full
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || sw_reset);
    // Long enough to clear the pin and transmit synchronisers
    sequence pin_low_s;
        !power_down_interrupt_pin_n [*5];
    endsequence
    sequence tx_idle_s;
        !tx_en [*6];
    endsequence
    pin_power_a: assert property (pin_low_s |-> !phy_enable)
        else $error("phy enabled with pin low");
    oe_match_a: assert property (col_oe == mii_out_oe)
        else $error("collision enable differs from mii enable");
    iso_col_a: assert property (!mii_out_oe [*2] |-> !col)
        else $error("collision driven while isolated");
    pd_col_a: assert property (!phy_enable [*2] |-> !col)
        else $error("collision driven while powered down");
    col_drop_a: assert property (tx_idle_s |-> !col)
        else $error("collision high after transmit ended");
    dup_auto_a: assert property (an_enable |-> duplex_full == an_duplex_full)
        else $error("manual duplex used under negotiation");
    restart_hold_a: assert property (an_restart_req && !an_started |=> an_restart_req)
        else $error("restart cleared before start");
    restart_en_a: assert property ($rose(an_restart_req) |-> an_enable || $past(an_enable))
        else $error("restart taken with negotiation off");
endmodule // bmc_sva
`default_nettype wire

// File: verif/mdio_station.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_station #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic clk,
    input wire logic mdio_line,
    output logic mdc,
    output logic mdio
);
    initial begin
        mdc = 1'b0;
        mdio = 1'b1;
    end
    // One frame, full preamble each time; released line reads as pull-up
    task automatic frame(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'h1, wr ? 2'h1 : 2'h2, PHY_ADDR, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            mdio <= (wr || i > 17) ? bits[i] : 1'b1;
            repeat (4) @(posedge clk);
            rd = {rd[14:0], mdio_line};
            mdc <= 1'b1;
            repeat (4) @(posedge clk);
            mdc <= 1'b0;
        end
    endtask
endmodule // mdio_station
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst, pin_n, strap, an_en, an_st, an_dup, tx_en, rs;
    logic mdc, st_mdio, mdio_out, mdio_oe, col, col_oe, mii_oe, phy_en, an_req, dup_full;
    wire logic mdio_line;
    int n_fail, n_compared, seed;
    logic [15:0] wd, rd;
    // Shared line: device wins while it drives
    assign mdio_line = mdio_oe ? mdio_out : st_mdio;
    basic_mode_control_upper uut (.clk, .rst, .sw_reset(1'b0), .mdc, .mdio_in(mdio_line),
        .mdio_out, .mdio_oe, .power_down_interrupt_pin_n(pin_n), .duplex_strap(strap),
        .an_enable(an_en), .an_started(an_st), .an_duplex_full(an_dup), .tx_en, .col,
        .col_oe, .mii_out_oe(mii_oe), .phy_enable(phy_en), .an_restart_req(an_req),
        .duplex_full(dup_full));
    mdio_station st (.clk, .mdio_line, .mdc, .mdio(st_mdio));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Control bits kept, reserved bits zero
    function automatic logic [15:0] exp_word(input logic [15:0] w, input logic r);
        return (w & 16'h0d80) | {6'h00, r, 9'h000};
    endfunction
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        n_fail = 0;
        n_compared = 0;
        seed = 32'hf946;
        rs = 1'b0;
        {rst, pin_n, an_st, tx_en, an_en, an_dup} = 6'h30;
        strap = 1'($random(seed));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        st.frame(1'b0, 5'h00, 16'h0000, rd);
        chk("reset word", {7'h00, strap, 8'h00}, rd);
        // Corner words first, then random ones
        for (int k = 0; k < 8; k++) begin
            wd = (k == 0) ? 16'hffff : (k == 1) ? 16'h0200 : (k == 2) ? 16'h0080 : 16'($random(seed));
            an_en <= (k == 1) ? 1'b1 : (k == 0) ? 1'b0 : 1'($random(seed));
            an_dup <= 1'($random(seed));
            st.frame(1'b1, 5'h00, wd, rd);
            rs = rs | (wd[9] & an_en);
            repeat (6) @(posedge clk);
            chk("restart req", 16'(rs), 16'(an_req));
            chk("phy enable", 16'(!wd[11]), 16'(phy_en));
            chk("mii oe", 16'(!wd[10]), 16'(mii_oe));
            chk("col oe", 16'(!wd[10]), 16'(col_oe));
            chk("duplex", 16'(an_en ? an_dup : wd[8]), 16'(dup_full));
            st.frame(1'b0, 5'h00, 16'h0000, rd);
            chk("readback", exp_word(wd, rs), rd);
            tx_en <= 1'b1;
            repeat (8) @(posedge clk);
            chk("col on", 16'(wd[7] & !wd[10] & !wd[11]), 16'(col));
            tx_en <= 1'b0;
            repeat (6) @(posedge clk);
            chk("col off", 16'h0000, 16'(col));
            if (rs) begin
                // A zero written to the restart bit leaves the request standing
                st.frame(1'b1, 5'h00, wd & 16'hfdff, rd);
                repeat (6) @(posedge clk);
                chk("restart kept", 16'h0001, 16'(an_req));
                an_st <= 1'b1;
                @(posedge clk);
                an_st <= 1'b0;
                rs = 1'b0;
                repeat (3) @(posedge clk);
                chk("restart clear", 16'h0000, 16'(an_req));
            end
        end
        // Pin power down latches the bit
        st.frame(1'b1, 5'h00, 16'h0000, rd);
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("pin pd", 16'h0000, 16'(phy_en));
        pin_n <= 1'b1;
        st.frame(1'b0, 5'h00, 16'h0000, rd);
        chk("pin bit", 16'h0001, 16'(rd[11]));
        st.frame(1'b0, 5'h03, 16'h0000, rd);
        chk("other reg", 16'h0000, rd);
        end_of_test();
    end
endmodule // testbench
bind basic_mode_control_upper bmc_sva sva (.clk, .rst, .sw_reset, .power_down_interrupt_pin_n,
    .an_enable, .an_started, .an_duplex_full, .tx_en, .col, .col_oe, .mii_out_oe, .phy_enable,
    .an_restart_req, .duplex_full);
`default_nettype wire
